// ===== design/agtl_addr_regs.v
// address register file with one write port and a registered read port
`timescale 1ns/1ns
module agtl_addr_regs
#(
   parameter W  = 16,
   parameter AW = 4
)
(
   // clock and reset
   input  wire          ref_clk,
   input  wire          reset_n,
   // write port
   input  wire          wr_en,
   input  wire [AW-1:0] wr_idx,
   input  wire [W-1:0]  wr_data,
   // read port
   input  wire [AW-1:0] rd_idx,
   output reg  [W-1:0]  rd_data_q
);

   localparam DEPTH = 1 << AW;

   reg [W-1:0] mem_q [0:DEPTH-1];

   genvar g;
   generate
      for (g = 0; g < DEPTH; g = g + 1)
      begin : g_entry
         always @(posedge ref_clk or negedge reset_n)
         begin
            if (!reset_n)
               mem_q[g] <= {W{1'b0}};
            else if (wr_en && (wr_idx == g))
               mem_q[g] <= wr_data;
         end
      end
   endgenerate

   // old contents are returned on a same-edge write; the caller forwards
   always @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         rd_data_q <= {W{1'b0}};
      else
         rd_data_q <= mem_q[rd_idx];
   end

endmodule

// ===== design/agtl_core.v
// address generator transfer and logic datapath with its register port
`timescale 1ns/1ns
`include "agtl_defines.vh"
module agtl_core
#(
   parameter W = 16
)
(
   // clock and reset
   input  wire                     ref_clk,
   input  wire                     reset_n,
   // instruction port from the sequencer
   input  wire                     instr_valid,
   input  wire [`AGTL_INSTR_W-1:0] instr,
   input  wire                     data_substitute_select,
   input  wire [W-1:0]             data_in,
   // address port
   output reg  [W-1:0]             addr_out_q,
   output reg                      addr_valid_q,
   // data port output
   output reg  [W-1:0]             data_out_q,
   output reg                      data_out_en_q,
   // status
   output reg                      compare_zero_flag_q,
   // register port
   input  wire [`AGTL_RA_W-1:0]    reg_addr,
   input  wire [W-1:0]             reg_wdata,
   input  wire                     reg_wr,
   input  wire                     reg_rd,
   output reg  [W-1:0]             reg_rdata_q
);

   // stage one: captured instruction, substitute and data port
   reg                      s1_valid_q;
   reg [`AGTL_INSTR_W-1:0]  s1_instr_q;
   reg                      s1_subst_q;
   reg [W-1:0]              s1_data_q;

   // small register banks
   reg [W-1:0]              index_q  [0:3];
   reg [W-1:0]              cmp_q    [0:3];
   reg [W-1:0]              offset_q [0:7];

   // control register
   reg [1:0]                ctrl_q;
   wire                     bank_sel;
   wire                     post_update;

   // forwarding of the last address register write
   reg                      fwd_valid_q;
   reg [3:0]                fwd_idx_q;
   reg [W-1:0]              fwd_data_q;

   // address register file
   wire [W-1:0]             rf_rdata;
   reg                      rf_we;
   reg [W-1:0]              rf_wdata;
   wire [3:0]               rf_widx;

   // decode
   wire [3:0]               op4;
   wire [5:0]               op6;
   wire [1:0]               fld2;
   wire                     is_idx_copy;
   wire                     is_to_dport;
   wire                     is_out_same;
   wire                     is_out_ofs;
   wire                     is_out_cmp;
   wire                     is_lsl;
   wire                     is_asr;
   wire                     is_and;
   wire                     is_or;
   wire                     is_xor;
   wire                     is_logic;
   wire                     is_update;

   // operands and results
   wire [W-1:0]             r_val;
   wire [W-1:0]             src_val;
   wire [W-1:0]             ofs_val;
   wire [2:0]               ofs_slot;
   reg  [2:0]               lu_op;
   wire [W-1:0]             lu_result;
   wire                     lu_zero;

   // execution outputs
   reg  [W-1:0]             y_d;
   reg                      y_en_d;
   reg                      ofs_we;
   reg                      cmp_we;

   reg  [W-1:0]             rd_mux;
   integer                  k;

   assign bank_sel    = ctrl_q[`AGTL_CTRL_BANK_BIT];
   assign post_update = ctrl_q[`AGTL_CTRL_POST_BIT];

   // capture the instruction together with the substitute input and data port
   always @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         s1_valid_q <= 1'b0;
         s1_instr_q <= {`AGTL_INSTR_W{1'b0}};
         s1_subst_q <= 1'b0;
         s1_data_q  <= {W{1'b0}};
      end
      else
      begin
         s1_valid_q <= instr_valid;
         s1_instr_q <= instr;
         s1_subst_q <= data_substitute_select;
         s1_data_q  <= data_in;
      end
   end

   // the file is read with the raw instruction index at the capture edge,
   // so its registered data line up with the captured word in stage one;
   // a write committed at that same edge is not seen and is forwarded below
   agtl_addr_regs
   #(
      .W  (W),
      .AW (4)
   )
   u_addr_regs
   (
      .ref_clk   (ref_clk),
      .reset_n   (reset_n),
      .wr_en     (rf_we),
      .wr_idx    (rf_widx),
      .wr_data   (rf_wdata),
      .rd_idx    (instr[3:0]),
      .rd_data_q (rf_rdata)
   );

   // decode of the captured word
   assign op4  = s1_instr_q[9:6];
   assign op6  = s1_instr_q[9:4];
   assign fld2 = s1_instr_q[5:4];

   // opcodes not listed here fall through every branch and do nothing
   assign is_idx_copy = s1_valid_q && (op4 == `AGTL_OP4_IDX_COPY);
   assign is_out_cmp  = s1_valid_q && (op4 == `AGTL_OP4_OUT_CMP);
   assign is_out_ofs  = s1_valid_q && (op4 == `AGTL_OP4_OUT_OFS);
   assign is_xor  = s1_valid_q && (op4 == `AGTL_OP4_XOR);
   assign is_and  = s1_valid_q && (op4 == `AGTL_OP4_AND);
   assign is_or   = s1_valid_q && (op4 == `AGTL_OP4_OR);
   assign is_to_dport = s1_valid_q && (op6 == `AGTL_OP6_TO_DPORT);
   assign is_out_same = s1_valid_q && (op6 == `AGTL_OP6_OUT_SAME);
   assign is_lsl  = s1_valid_q && (op6 == `AGTL_OP6_LSL);
   assign is_asr  = s1_valid_q && (op6 == `AGTL_OP6_ASR);

   assign is_logic  = is_and | is_or | is_xor;
   assign is_update = is_logic | is_lsl | is_asr;

   // address register value, forwarded when the previous instruction wrote it
   assign r_val = (fwd_valid_q && (fwd_idx_q == s1_instr_q[3:0])) ? fwd_data_q : rf_rdata;

   // substitute selects the data port in place of the address register
   assign src_val = s1_subst_q ? s1_data_q : r_val;

   // offset index 3 is the data port in either bank
   assign ofs_slot = {bank_sel, fld2};
   assign ofs_val  = (fld2 == `AGTL_OFS_DATAPORT) ? s1_data_q
                                                  : offset_q[ofs_slot];

   always @*
   begin
      lu_op = `AGTL_LU_AND;
      if (is_or)
         lu_op = `AGTL_LU_OR;
      else if (is_xor)
         lu_op = `AGTL_LU_XOR;
      else if (is_lsl)
         lu_op = `AGTL_LU_LSL;
      else if (is_asr)
         lu_op = `AGTL_LU_ASR;
   end

   agtl_logic_unit
   #(
      .W (W)
   )
   u_logic_unit
   (
      .op_sel      (lu_op),
      .opnd_a      (src_val),
      .opnd_b      (ofs_val),
      .result      (lu_result),
      .result_zero (lu_zero)
   );

   assign rf_widx = s1_instr_q[3:0];

   // execution: address port value and register writes
   always @*
   begin
      y_d      = {W{1'b0}};
      y_en_d   = 1'b0;
      rf_we    = 1'b0;
      rf_wdata = {W{1'b0}};
      ofs_we   = 1'b0;
      cmp_we   = 1'b0;
      if (is_idx_copy)
      begin
         rf_we    = 1'b1;
         rf_wdata = index_q[fld2];
      end
      else if (is_out_ofs)
      begin
         y_d    = src_val;
         y_en_d = 1'b1;
         ofs_we = 1'b1;
      end
      else if (is_out_cmp)
      begin
         y_d    = src_val;
         y_en_d = 1'b1;
         cmp_we = 1'b1;
      end
      else if (is_out_same)
      begin
         // without substitute the register keeps its value, so no write
         y_d      = src_val;
         y_en_d   = 1'b1;
         rf_we    = s1_subst_q;
         rf_wdata = s1_data_q;
      end
      else if (is_update)
      begin
         // the pre-update value is the operand, which is the data port
         // value when substitute is set; the result always goes back to r
         y_d      = post_update ? lu_result : src_val;
         y_en_d   = 1'b1;
         rf_we    = 1'b1;
         rf_wdata = lu_result;
      end
   end

   // output registers and flag
   always @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         addr_out_q          <= {W{1'b0}};
         addr_valid_q        <= 1'b0;
         data_out_q          <= {W{1'b0}};
         data_out_en_q       <= 1'b0;
         compare_zero_flag_q <= 1'b0;
      end
      else
      begin
         addr_valid_q  <= y_en_d;
         data_out_en_q <= is_to_dport;
         if (y_en_d)
            addr_out_q <= y_d;
         // substitute has no effect here: the register value is driven
         if (is_to_dport)
            data_out_q <= r_val;
         if (is_logic)
            compare_zero_flag_q <= lu_zero;
      end
   end

   // forwarding record of the write committed at this edge; it lives one
   // cycle only, which covers the one instruction whose file read raced
   // the write, later instructions read the file itself
   always @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         fwd_valid_q <= 1'b0;
         fwd_idx_q   <= 4'h0;
         fwd_data_q  <= {W{1'b0}};
      end
      else
      begin
         fwd_valid_q <= rf_we;
         fwd_idx_q   <= rf_widx;
         fwd_data_q  <= rf_wdata;
      end
   end

   // offset and compare banks; index registers are loaded from the register port
   always @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         for (k = 0; k < 8; k = k + 1)
            offset_q[k] <= {W{1'b0}};
         for (k = 0; k < 4; k = k + 1)
         begin
            cmp_q[k]   <= {W{1'b0}};
            index_q[k] <= {W{1'b0}};
         end
         ctrl_q <= `AGTL_CTRL_RESET;
      end
      else
      begin
         // index 3 names the data port, so there is nothing to store
         if (ofs_we && (fld2 != `AGTL_OFS_DATAPORT))
            offset_q[ofs_slot] <= src_val;
         if (cmp_we)
            cmp_q[fld2] <= src_val;
         if (reg_wr && (reg_addr == `AGTL_RA_CTRL))
            ctrl_q <= reg_wdata[1:0];
         if (reg_wr && (reg_addr[4:2] == `AGTL_RA_INDEX_BASE >> 2))
            index_q[reg_addr[1:0]] <= reg_wdata;
      end
   end

   // register port read mux; unmapped offsets read zero, and so do the
   // two offset slots that stand for the data port
   always @*
   begin
      rd_mux = {W{1'b0}};
      if (reg_addr == `AGTL_RA_CTRL)
         rd_mux = {{(W-2){1'b0}}, ctrl_q};
      else if (reg_addr == `AGTL_RA_STATUS)
         rd_mux = {{(W-1){1'b0}}, compare_zero_flag_q};
      else if (reg_addr == `AGTL_RA_LAST_ADDR)
         rd_mux = addr_out_q;
      else if (reg_addr[4:2] == (`AGTL_RA_INDEX_BASE >> 2))
         rd_mux = index_q[reg_addr[1:0]];
      else if (reg_addr[4:2] == (`AGTL_RA_CMP_BASE >> 2))
         rd_mux = cmp_q[reg_addr[1:0]];
      else if ((reg_addr[4:3] == (`AGTL_RA_OFS_BASE >> 3)) && (reg_addr[1:0] != 2'h3))
         rd_mux = offset_q[reg_addr[2:0]];
   end

   // read data stand for one cycle only and are zero otherwise
   always @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         reg_rdata_q <= {W{1'b0}};
      else if (reg_rd)
         reg_rdata_q <= rd_mux;
      else
         reg_rdata_q <= {W{1'b0}};
   end

endmodule

// ===== design/agtl_defines.vh
// opcode fields, register offsets and layout constants for the transfer and logic unit
`ifndef AGTL_DEFINES_VH
`define AGTL_DEFINES_VH

// instruction word
`define AGTL_INSTR_W        10
`define AGTL_OP4_IDX_COPY   4'h8
`define AGTL_OP4_OUT_CMP    4'h2
`define AGTL_OP4_OUT_OFS    4'h3
`define AGTL_OP4_XOR        4'h5
`define AGTL_OP4_AND        4'h6
`define AGTL_OP4_OR         4'h7
`define AGTL_OP6_TO_DPORT   6'h04
`define AGTL_OP6_OUT_SAME   6'h05
`define AGTL_OP6_LSL        6'h06
`define AGTL_OP6_ASR        6'h07
`define AGTL_OFS_DATAPORT   2'h3

// logic unit operation select
`define AGTL_LU_AND         3'h0
`define AGTL_LU_OR          3'h1
`define AGTL_LU_XOR         3'h2
`define AGTL_LU_LSL         3'h3
`define AGTL_LU_ASR         3'h4

// register port offsets
`define AGTL_RA_W           5
`define AGTL_RA_CTRL        5'h00
`define AGTL_RA_STATUS      5'h01
`define AGTL_RA_LAST_ADDR   5'h02
`define AGTL_RA_INDEX_BASE  5'h04
`define AGTL_RA_CMP_BASE    5'h08
`define AGTL_RA_OFS_BASE    5'h10

// control register fields and reset value
`define AGTL_CTRL_BANK_BIT  0
`define AGTL_CTRL_POST_BIT  1
`define AGTL_CTRL_RESET     2'h0

`endif

// ===== design/agtl_logic_unit.v
// combinational and/or/xor and single-bit shift unit with zero detect
`timescale 1ns/1ns
`include "agtl_defines.vh"
module agtl_logic_unit
#(
   parameter W = 16
)
(
   // operation
   input  wire [2:0]   op_sel,
   input  wire [W-1:0] opnd_a,
   input  wire [W-1:0] opnd_b,
   // result
   output reg  [W-1:0] result,
   output wire         result_zero
);

   always @*
   begin
      case (op_sel)
         `AGTL_LU_AND: result = opnd_a & opnd_b;
         `AGTL_LU_OR:  result = opnd_a | opnd_b;
         `AGTL_LU_XOR: result = opnd_a ^ opnd_b;
         `AGTL_LU_LSL: result = {opnd_a[W-2:0], 1'b0};
         `AGTL_LU_ASR: result = {opnd_a[W-1], opnd_a[W-1:1]};
         default:      result = opnd_a;
      endcase
   end

   assign result_zero = (result == {W{1'b0}});

endmodule

// ===== verification/agtl_bus_model.sv
// shared data bus model seen at the data port
`timescale 1ns/1ns
module agtl_bus_model
(
   // clock
   input  wire        ref_clk,
   // sequencer side
   input  wire        seq_en,
   input  wire [15:0] seq_data,
   // device side
   input  wire        dev_en,
   input  wire [15:0] dev_data,
   // bus at the device input
   output wire [15:0] bus
);
   reg [15:0] last_q = 16'h0000;

   // a released bus must not look like the last value
   assign bus = dev_en ? dev_data : (seq_en ? seq_data : ~last_q);

   always @(posedge ref_clk)
      if (dev_en || seq_en)
         last_q <= bus;
endmodule

// ===== verification/agtl_core_props.sv
// concurrent checks on the transfer and logic unit ports
`timescale 1ns/1ns
module agtl_core_props
#(
   parameter W = 16
)
(
   // clock and reset
   input wire         ref_clk,
   input wire         reset_n,
   // instruction port
   input wire         instr_valid,
   input wire [9:0]   instr,
   input wire         data_substitute_select,
   input wire [W-1:0] data_in,
   // outputs
   input wire [W-1:0] addr_out_q,
   input wire         addr_valid_q,
   input wire [W-1:0] data_out_q,
   input wire         data_out_en_q,
   input wire         compare_zero_flag_q
);
   logic [W-1:0] d1_q;
   logic [W-1:0] d2_q;
   wire  [3:0]   op4 = instr[9:6];
   wire  [5:0]   op6 = instr[9:4];
   wire          ds = instr_valid && data_substitute_select;
   wire          lgc = instr_valid && (op4 == 4'h5 || op4 == 4'h6 || op4 == 4'h7);
   wire          cpy = op4 == 4'h2 || op4 == 4'h3 || op6 == 6'h05;
   wire          yout = lgc || (instr_valid && (cpy || op6 == 6'h06 || op6 == 6'h07));
   wire          dpo = instr_valid && op6 == 6'h04;

   // data port value two edges back
   always @(posedge ref_clk)
   begin
      d1_q <= data_in;
      d2_q <= d1_q;
   end

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!reset_n);

   out_latency_a: assert property (yout |-> ##2 addr_valid_q)
      else $error("address output missing");
   out_cause_a: assert property (addr_valid_q |-> $past(yout, 2))
      else $error("address output without instruction");
   dport_out_a: assert property (dpo |-> ##2 data_out_en_q && !addr_valid_q)
      else $error("data port output missing");
   dport_cause_a: assert property (data_out_en_q |-> $past(dpo, 2))
      else $error("data port driven without instruction");
   idx_quiet_a: assert property (instr_valid && op4 == 4'h8
      |-> ##2 !addr_valid_q && !data_out_en_q) else $error("index copy drove a port");
   subst_out_a: assert property (ds && cpy |-> ##2 addr_out_q == d2_q)
      else $error("substitute value not on address port");
   addr_hold_a: assert property (!addr_valid_q |-> $stable(addr_out_q))
      else $error("address port changed without strobe");
   dout_hold_a: assert property (!data_out_en_q |-> $stable(data_out_q))
      else $error("data port changed without strobe");
   flag_cause_a: assert property (!$stable(compare_zero_flag_q) |-> $past(lgc, 2))
      else $error("zero flag changed without logic op");
   lsl_sub_a: assert property (ds && op6 == 6'h06 |-> ##2
      (addr_out_q == d2_q || addr_out_q == {d2_q[W-2:0], 1'b0})) else $error("left shift wrong");
   asr_sub_a: assert property (ds && op6 == 6'h07 |-> ##2
      (addr_out_q == d2_q || addr_out_q == {d2_q[W-1], d2_q[W-1:1]}))
      else $error("right shift wrong");
   port_zero_a: assert property (ds && op4 == 4'h5 && instr[5:4] == 2'h3
      |-> ##2 compare_zero_flag_q) else $error("port xor port not zero");
endmodule

bind agtl_core agtl_core_props #(.W(W)) agtl_core_props_inst
(
   .ref_clk, .reset_n, .instr_valid, .instr, .data_substitute_select, .data_in,
   .addr_out_q, .addr_valid_q, .data_out_q, .data_out_en_q, .compare_zero_flag_q
);

// ===== verification/test_agtl_core.sv
// self-checking bench for the transfer and logic unit
`timescale 1ns/1ns
module test_agtl_core;
   localparam W = 16;
   localparam [9:0]   LOP [0:4] = '{10'h155, 10'h1d5, 10'h195, 10'h065, 10'h075};
   localparam [W-1:0] LA  [0:4] = '{16'hf0ff, 16'hf0f0, 16'hf0f0, 16'h8a32, 16'h8a32};
   localparam [W-1:0] LR  [0:4] = '{16'hfff0, 16'hffff, 16'h0000, 16'h1464, 16'hc519};
   localparam [4:0]   LZ = 5'b11100;
   reg          ref_clk = 1'b0;
   reg          reset_n = 1'b0;
   reg          instr_valid = 1'b0;
   reg  [9:0]   instr = 10'h000;
   reg          data_substitute_select = 1'b0;
   reg          seq_en = 1'b0;
   reg  [W-1:0] seq_data = 16'h0000;
   reg  [4:0]   reg_addr = 5'h00;
   reg  [W-1:0] reg_wdata = 16'h0000;
   reg          reg_wr = 1'b0;
   reg          reg_rd = 1'b0;
   wire [W-1:0] data_in;
   wire [W-1:0] addr_out_q;
   wire [W-1:0] data_out_q;
   wire [W-1:0] reg_rdata_q;
   wire         addr_valid_q;
   wire         data_out_en_q;
   wire         compare_zero_flag_q;
   integer      fail_count = 0;
   integer      check_count = 0;
   integer      k;
   integer      m;

   agtl_core #(.W(W)) agtl_core_inst
   (
      .ref_clk, .reset_n, .instr_valid, .instr, .data_substitute_select,
      .data_in, .addr_out_q, .addr_valid_q, .data_out_q, .data_out_en_q,
      .compare_zero_flag_q, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q
   );
   agtl_bus_model agtl_bus_model_inst
   (
      .ref_clk, .seq_en, .seq_data, .dev_en(data_out_en_q),
      .dev_data(data_out_q), .bus(data_in)
   );

   always #10 ref_clk = ~ref_clk;

   task stop_test;
      if (fail_count == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task chk(input string nm, input [W-1:0] seen, input [W-1:0] exp);
      check_count = check_count + 1;
      if (seen !== exp)
      begin
         fail_count = fail_count + 1;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task wr(input [4:0] a, input [W-1:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task rd(input [4:0] a, input [W-1:0] exp);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      chk("rdata", reg_rdata_q, exp);
   endtask

   // outputs land one edge after the instruction is taken
   task op(input [9:0] i, input s, input [W-1:0] d, input [1:0] ev, input [W-1:0] ea);
      @(posedge ref_clk);
      instr_valid <= 1'b1;
      instr <= i;
      data_substitute_select <= s;
      seq_en <= 1'b1;
      seq_data <= d;
      @(posedge ref_clk);
      instr_valid <= 1'b0;
      seq_en <= 1'b0;
      @(posedge ref_clk);
      #1;
      chk("strobes", {14'h0000, addr_valid_q, data_out_en_q}, {14'h0000, ev});
      if (ev[1])
         chk("addr", addr_out_q, ea);
   endtask

   task rr(input [3:0] r, input [W-1:0] exp);
      op({6'h05, r}, 1'b0, 16'h5a5a, 2'b10, exp);
   endtask

   task t_reset;
      chk("addr", addr_out_q, 16'h0000);
      rd(5'h00, 16'h0000);
      rd(5'h01, 16'h0000);
      rd(5'h03, 16'h0000);
      rr(4'h0, 16'h0000);
   endtask

   task t_xfer;
      wr(5'h05, 16'h1234);
      op(10'h217, 1'b0, 16'h5555, 2'b00, 16'h0000);
      rr(4'h7, 16'h1234);
      op(10'h047, 1'b1, 16'h5555, 2'b01, 16'h0000);
      chk("dout", data_out_q, 16'h1234);
      wr(5'h00, 16'h0001);
      op(10'h0d7, 1'b0, 16'h5555, 2'b10, 16'h1234);
      rd(5'h15, 16'h1234);
      rd(5'h11, 16'h0000);
      op(10'h0c7, 1'b1, 16'h00aa, 2'b10, 16'h00aa);
      rd(5'h14, 16'h00aa);
      op(10'h0b7, 1'b0, 16'h5555, 2'b10, 16'h1234);
      rd(5'h0b, 16'h1234);
      op(10'h0a7, 1'b1, 16'h0bee, 2'b10, 16'h0bee);
      rd(5'h0a, 16'h0bee);
      rr(4'h7, 16'h1234);
      op(10'h057, 1'b1, 16'h4321, 2'b10, 16'h4321);
      rr(4'h7, 16'h4321);
   endtask

   task t_logic;
      for (m = 0; m < 2; m = m + 1)
      begin
         wr(5'h00, m ? 16'h0003 : 16'h0001);
         op(10'h0d0, 1'b1, 16'h0f0f, 2'b10, 16'h0f0f);
         for (k = 0; k < 5; k = k + 1)
         begin
            op(10'h055, 1'b1, LA[k], 2'b10, LA[k]);
            op(LOP[k], 1'b0, 16'h5a5a, 2'b10, m ? LR[k] : LA[k]);
            chk("zero", {15'h0000, compare_zero_flag_q}, {15'h0000, LZ[k]});
            rr(4'h5, LR[k]);
         end
      end
   endtask

   task t_port;
      wr(5'h00, 16'h0002);
      op(10'h0d0, 1'b1, 16'h00ff, 2'b10, 16'h00ff);
      op(10'h195, 1'b1, 16'h1234, 2'b10, 16'h0034);
      rr(4'h5, 16'h0034);
      op(10'h066, 1'b1, 16'h8a32, 2'b10, 16'h1464);
      op(10'h077, 1'b1, 16'h8a32, 2'b10, 16'hc519);
      rr(4'h7, 16'hc519);
      for (k = 0; k < 2; k = k + 1)
      begin
         wr(5'h00, k ? 16'h0003 : 16'h0002);
         op(10'h055, 1'b1, 16'h1234, 2'b10, 16'h1234);
         op(10'h175, k[0], 16'h1234, 2'b10, 16'h0000);
         chk("zero", {15'h0000, compare_zero_flag_q}, 16'h0001);
      end
   endtask

   initial
   begin
      repeat (20) @(posedge ref_clk);
      reset_n <= 1'b1;
      t_reset;
      t_xfer;
      t_logic;
      t_port;
      stop_test;
   end

   initial
   begin
      #100000;
      fail_count = fail_count + 1;
      stop_test;
   end
endmodule
